// file: adc_control_registers.sv
// Control and result registers for one 12-bit converter.
// Assumes the analog core returns conversion bits and a done pulse on core_clk.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

// Behaviour
// - Justify 0: high byte holds bits 11..4, low byte top nibble bits 3..0.
// - Justify 1: high byte low nibble bits 11..8, low byte bits 7..0.
// - Data bit positions without result bits read as zero.
// - Power enable low powers down converter; result registers hold.
// - Conversion starts on start bit low-high-low sequence, not level.
// - Busy flag sets on start sequence, clears on completion.
// - Channel codes 0..7 route inputs 0..7; codes 8..15 float.
// - Source codes pick external, supply /1/2/4 or amplifier /1/2/4.
// - Source 8 and 9 pick proximity amps; 10 and 11 ground. Source 9 drives internal_source 0, the same as ground.
// - Internal source disconnects the external channel input.
// - Converter clock is system clock divided by two to field power.
// - Unimplemented control bits read as zero.
// - Amplifier input select: 0 external pin, 1 bandgap.
// - Reference: 00 supply, 01 pin, 1x amplifier; internal wins.
// - Amplifier gain codes 00..11 give gains 1..4.
// - Selected analog pins lose digital function and pull-high.
// - Completion raises the converter interrupt request pulse.
module adc_control_registers #(
  parameter int CHANNELS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [11:0] conv_result,
  input wire logic conv_done,
  output logic conv_power_on,
  output logic conv_start,
  output logic conv_clk_en,
  output logic conv_busy,
  output logic conv_irq,
  output logic [CHANNELS-1:0] channel_connect,
  output logic [CHANNELS-1:0] pin_analog_mode,
  output logic [2:0] internal_source,
  output logic external_path_on,
  output logic [1:0] reference_route,
  output logic gain_amp_on,
  output logic gain_amp_bandgap,
  output logic [2:0] gain_amp_gain
);

  // ****************************************
  // Control registers
  // ****************************************
  logic start_bit_ff;
  logic power_ff;
  logic justify_ff;
  logic [3:0] channel_ff;
  logic [7:0] src_clk_ff;
  logic [7:0] amp_ref_ff;
  logic busy_ff;
  logic [11:0] result_ff;
  logic [7:0] rdata_ff;
  logic [6:0] div_cnt_ff;
  logic done_pulse_ff;
  logic [7:0] main_rd;
  logic [7:0] low_rd;
  logic [7:0] high_rd;
  logic wr_main;

  assign wr_main = reg_wr && (reg_addr == adc_ctrl_pkg::OFF_CONV_MAIN);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_bit_ff <= 1'b0;
      power_ff <= 1'b0;
      justify_ff <= 1'b0;
      channel_ff <= 4'h0;
    end else if (wr_main) begin
      start_bit_ff <= reg_wdata[adc_ctrl_pkg::BIT_START];
      power_ff <= reg_wdata[adc_ctrl_pkg::BIT_POWER];
      justify_ff <= reg_wdata[adc_ctrl_pkg::BIT_JUSTIFY];
      channel_ff <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_clk_ff <= adc_ctrl_pkg::RST_REG;
      amp_ref_ff <= adc_ctrl_pkg::RST_REG;
    end else if (reg_wr) begin
      if (reg_addr == adc_ctrl_pkg::OFF_SRC_CLK) begin
        src_clk_ff <= reg_wdata & adc_ctrl_pkg::MASK_SRC_CLK;
      end
      if (reg_addr == adc_ctrl_pkg::OFF_AMP_REF) begin
        amp_ref_ff <= reg_wdata & adc_ctrl_pkg::MASK_AMP_REF;
      end
    end
  end

  // ****************************************
  // Start sequence and busy
  // ****************************************
  // Falling edge of start bit
  assign conv_start = wr_main && start_bit_ff && !reg_wdata[adc_ctrl_pkg::BIT_START]
    && power_ff && !busy_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
    end else if (conv_start) begin
      busy_ff <= 1'b1;
    end else if (conv_done || !power_ff) begin
      busy_ff <= 1'b0;
    end
  end
  assign conv_busy = busy_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= 12'h000;
    end else if (conv_done && busy_ff && power_ff) begin
      result_ff <= conv_result;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_pulse_ff <= 1'b0;
    end else begin
      done_pulse_ff <= conv_done && busy_ff && power_ff;
    end
  end
  assign conv_irq = done_pulse_ff;

  // ****************************************
  // Converter clock divider
  // ****************************************
  // Divide by two to the field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= 7'h00;
    end else if (!power_ff) begin
      div_cnt_ff <= 7'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 7'h01;
    end
  end

  function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    div_tick = (cnt & mask) == mask;
  endfunction

  assign conv_clk_en = power_ff && div_tick(div_cnt_ff, src_clk_ff[2:0]);
  assign conv_power_on = power_ff;

  // ****************************************
  // Analog routing
  // ****************************************
  logic [3:0] src_sel;
  logic src_internal;
  assign src_sel = src_clk_ff[7:4];

  always_comb begin
    src_internal = 1'b1;
    internal_source = 3'h0;
    case (src_sel)
      4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: src_internal = 1'b0;
      4'h1, 4'h2, 4'h3: internal_source = {1'b0, src_sel[1:0]};
      4'h5, 4'h6, 4'h7: internal_source = {1'b1, src_sel[1:0]};
      adc_ctrl_pkg::SRC_PROX0: internal_source = 3'h4;
      adc_ctrl_pkg::SRC_PROX1: internal_source = 3'h0;
      default: internal_source = 3'h0;
    endcase
  end
  // Code space reuse: 3'h4 on proximity and supply-zero/ground both 0
  // is not resolved: src_sel is not an output, so source 9 drives the same outputs as ground.

  assign external_path_on = power_ff && !src_internal;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign channel_connect[g] = external_path_on && (channel_ff == 4'(g));
      assign pin_analog_mode[g] = channel_connect[g];
    end
  endgenerate

  assign reference_route = amp_ref_ff[3] ? 2'b10 : amp_ref_ff[3:2];
  assign gain_amp_bandgap = amp_ref_ff[adc_ctrl_pkg::BIT_AMP_IN];
  assign gain_amp_on = amp_ref_ff[adc_ctrl_pkg::BIT_AMP_EN];
  assign gain_amp_gain = {1'b0, amp_ref_ff[1:0]} + 3'h1;

  // ****************************************
  // Read path
  // ****************************************
  // Left justified for justify 0, right justified for justify 1
  assign low_rd = justify_ff ? result_ff[7:0] : {result_ff[3:0], 4'h0};
  assign high_rd = justify_ff ? {4'h0, result_ff[11:8]} : result_ff[11:4];
  assign main_rd = {start_bit_ff, busy_ff, power_ff, justify_ff, channel_ff};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        adc_ctrl_pkg::OFF_RESULT_LOW: rdata_ff <= low_rd;
        adc_ctrl_pkg::OFF_RESULT_HIGH: rdata_ff <= high_rd;
        adc_ctrl_pkg::OFF_CONV_MAIN: rdata_ff <= main_rd;
        adc_ctrl_pkg::OFF_SRC_CLK: rdata_ff <= src_clk_ff;
        adc_ctrl_pkg::OFF_AMP_REF: rdata_ff <= amp_ref_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;

endmodule

// file: adc_control_registers_asserts.sv
// Checker for the converter register block.
// Assumes it is bound to every instance of adc_control_registers.
`timescale 1ns/10ps
module adc_control_registers_asserts #(
  parameter int CHANNELS = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic conv_done,
  input wire logic conv_power_on,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic conv_irq,
  input wire logic [CHANNELS-1:0] channel_connect,
  input wire logic [CHANNELS-1:0] pin_analog_mode,
  input wire logic external_path_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Properties
  // ****
  property p_start_set; conv_start |=> conv_busy; endproperty
  a_start_set: assert property (p_start_set) else $error("busy not set");
  property p_done_clr; conv_busy && conv_done |=> !conv_busy; endproperty
  a_done_clr: assert property (p_done_clr) else $error("busy not cleared");
  property p_irq; conv_busy && conv_done |=> conv_irq ##1 !conv_irq; endproperty
  a_irq: assert property (p_irq) else $error("request pulse wrong");
  property p_start_src;
    conv_start |-> reg_wr && reg_addr == 3'h2 && !reg_wdata[7] && !conv_busy;
  endproperty
  a_start_src: assert property (p_start_src) else $error("start without falling write");
  property p_off; !conv_power_on |-> !conv_start && channel_connect == '0; endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_ext_off; !external_path_on |-> channel_connect == '0; endproperty
  a_ext_off: assert property (p_ext_off) else $error("channel left on");
  property p_onehot; $onehot0(channel_connect); endproperty
  a_onehot: assert property (p_onehot) else $error("several channels");
  property p_pin; pin_analog_mode == channel_connect; endproperty
  a_pin: assert property (p_pin) else $error("pin mode differs");
endmodule
bind adc_control_registers adc_control_registers_asserts #(.CHANNELS(CHANNELS)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .conv_done(conv_done), .conv_power_on(conv_power_on),
  .conv_start(conv_start), .conv_busy(conv_busy), .conv_irq(conv_irq),
  .channel_connect(channel_connect), .pin_analog_mode(pin_analog_mode),
  .external_path_on(external_path_on));

// file: adc_core_model.sv
// Model of the analog conversion core.
// Assumes conv_start is a one-cycle pulse on core_clk.
`timescale 1ns/10ps
module adc_core_model #(
  parameter int DELAY = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic [11:0] sample_value,
  output logic [11:0] conv_result,
  output logic conv_done
);
  int cnt;
  logic [11:0] held = 12'h000;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt == 1);
      if (conv_start) begin
        cnt <= DELAY;
        held <= sample_value;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Stale data inverted so a late sample shows
  assign conv_result = conv_done ? held : ~held;
endmodule

// file: adc_ctrl_pkg.sv
// Package for the converter control register block.
// Assumes a plain address/strobe register port and one system clock.
package adc_ctrl_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFF_RESULT_LOW = 3'h0;
  localparam logic [2:0] OFF_RESULT_HIGH = 3'h1;
  localparam logic [2:0] OFF_CONV_MAIN = 3'h2;
  localparam logic [2:0] OFF_SRC_CLK = 3'h3;
  localparam logic [2:0] OFF_AMP_REF = 3'h4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_START = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_POWER = 5;
  localparam int BIT_JUSTIFY = 4;
  localparam int BIT_AMP_EN = 7;
  localparam int BIT_AMP_IN = 4;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] MASK_SRC_CLK = 8'hf7;
  localparam logic [7:0] MASK_AMP_REF = 8'h9f;

  // ****************************************
  // Source select codes
  // ****************************************
  localparam logic [3:0] SRC_PROX0 = 4'h8;
  localparam logic [3:0] SRC_PROX1 = 4'h9;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CONV_CLOCKS = 16;
  localparam logic [7:0] CONV_COUNT_W8 = 8'h10;

endpackage

// file: tb_adc_control_registers.sv
// Testbench for the converter register block.
// Assumes the core model and the bound checker.
`timescale 1ns/10ps
module tb_adc_control_registers;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] sample_value = 12'h000;
  logic [7:0] reg_rdata, channel_connect, pin_analog_mode;
  logic [11:0] conv_result;
  logic conv_done, conv_power_on, conv_start, conv_clk_en, conv_busy, conv_irq;
  logic [2:0] internal_source, gain_amp_gain;
  logic external_path_on, gain_amp_on, gain_amp_bandgap;
  logic [1:0] reference_route;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  always #4 core_clk = ~core_clk;
  adc_control_registers dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .conv_result, .conv_done, .conv_power_on, .conv_start, .conv_clk_en,
    .conv_busy, .conv_irq, .channel_connect, .pin_analog_mode, .internal_source,
    .external_path_on, .reference_route, .gain_amp_on, .gain_amp_bandgap, .gain_amp_gain);
  adc_core_model core (.core_clk, .rst_n, .conv_start, .sample_value, .conv_result,
    .conv_done);
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 5; a++) rd(a, 8'h00);
    wr(3'h3, 8'hff);
    rd(3'h3, 8'hf7);
    wr(3'h4, 8'hff);
    rd(3'h4, 8'h9f);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    wr(3'h3, 8'h00);
  endtask
  task automatic t_conv();
    sample_value = 12'habc;
    wr(3'h2, 8'ha0);
    repeat (5) @(posedge core_clk);
    chk(conv_busy, 1'b0);
    wr(3'h2, 8'h20);
    chk(conv_busy, 1'b1);
    rd(3'h2, 8'h60);
    for (n = 0; n < 100 && conv_busy; n++) @(posedge core_clk);
    #1;
    chk(conv_busy, 1'b0);
    rd(3'h1, 8'hab);
    rd(3'h0, 8'hc0);
    wr(3'h2, 8'h30);
    rd(3'h1, 8'h0a);
    rd(3'h0, 8'hbc);
  endtask
  task automatic t_off();
    sample_value = 12'h123;
    wr(3'h2, 8'h10);
    wr(3'h2, 8'h90);
    wr(3'h2, 8'h10);
    chk(conv_busy, 1'b0);
    rd(3'h1, 8'h0a);
    rd(3'h0, 8'hbc);
  endtask
  task automatic t_sel();
    wr(3'h2, 8'h20);
    for (int s = 0; s < 16; s++) begin
      wr(3'h3, 8'(s << 4));
      chk(external_path_on, s == 0 || s == 4 || s >= 12);
      if ((s >= 1 && s <= 3) || (s >= 5 && s <= 7)) begin
        chk(internal_source, 16'(s & 7));
      end
      if (s == 8) begin
        chk(internal_source, 16'h0004);
      end
    end
    wr(3'h3, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(3'h2, 8'(8'h20 + c));
      chk(channel_connect, c < 8 ? 16'(1 << c) : 16'h0000);
    end
  endtask
  task automatic t_amp();
    for (int g = 0; g < 4; g++) begin
      wr(3'h4, 8'(g));
      chk(gain_amp_gain, 16'(g + 1));
      wr(3'h4, 8'(g << 2));
      chk(reference_route, g > 1 ? 16'h0002 : 16'(g));
    end
    wr(3'h4, 8'h90);
    chk({gain_amp_on, gain_amp_bandgap}, 16'h0003);
    wr(3'h4, 8'h80);
    chk({gain_amp_on, gain_amp_bandgap}, 16'h0002);
  endtask
  task automatic t_div();
    for (int d = 0; d < 8; d++) begin
      wr(3'h3, 8'(d));
      n = 0;
      repeat (256) begin
        @(posedge core_clk);
        #1;
        n += conv_clk_en;
      end
      chk(16'(n), 16'(256 >> d));
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_conv();
    t_off();
    t_sel();
    t_amp();
    t_div();
    report_and_stop();
  end
  // Run needs about 2200 cycles
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule
